// ==== verilog/brake_pkg.sv ====
// constants for the brake interlock sequencer
package brake_pkg;
   // register offsets (word index as printed)
   localparam logic [11:0] ADDR_ON_DELAY = 12'h022a;
   localparam logic [11:0] ADDR_OFF_DELAY = 12'h022c;
   localparam logic [11:0] ADDR_SPEED_THR = 12'h0230;
   localparam logic [11:0] ADDR_DO_FUNC = 12'h0232;
   localparam logic [11:0] ADDR_STATUS = 12'h0234;
   localparam logic [15:0] DELAY_RESET = 16'h0000;
   localparam logic [15:0] THR_RESET = 16'h0000;
   localparam logic [7:0] FUNC_BRAKE = 8'h07;
   localparam logic [7:0] FUNC_RESET = 8'h07;
   localparam int signed ON_MAX_MS = 1000;
   localparam int signed OFF_MIN_MS = -1000;
   localparam int signed OFF_MAX_MS = 1000;
   // millisecond tick from the 250 MHz clock
   localparam int TIME_MS_NS = 1000000;
   localparam int CLK_NS = 4;
   localparam int TICK_CYCLES = TIME_MS_NS / CLK_NS;
   localparam int ST_BIT_OUT = 0;
   localparam int ST_BIT_RUN = 1;
   localparam int ST_BIT_STOP = 2;
   typedef enum logic [1:0] {
      ST_LOCKED,
      ST_ON_WAIT,
      ST_RELEASED,
      ST_OFF_WAIT
   } brake_state_t;
endpackage

// ==== verilog/ms_tick.sv ====
// millisecond tick generator
`timescale 1ns/100ps
module ms_tick #(
   parameter int TICK_CYCLES = brake_pkg::TICK_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic clear_i,
   output logic tick_o
);
   logic [31:0] cnt_r;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || clear_i) begin
         cnt_r <= 32'h0000_0000;
         tick_o <= 1'b0;
      end else if (cnt_r == 32'(TICK_CYCLES - 1)) begin
         cnt_r <= 32'h0000_0000;
         tick_o <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h0000_0001;
         tick_o <= 1'b0;
      end
   end
endmodule // ms_tick

// ==== verilog/brake_interlock_sequencer.sv ====
// brake interlock sequencer: servo-on/off to brake release output
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
module brake_interlock_sequencer #(
   parameter int TICK_CYCLES = brake_pkg::TICK_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [11:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic servo_on_i,
   input wire logic alarm_i,
   input wire logic emergency_stop_in_i,
   input wire logic signed [15:0] speed_i,
   output logic brake_release_o,
   output logic brake_interlock_o
);
   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic servo_on;
   logic fault;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
      end else begin
         sync1_r <= {emergency_stop_in_i, alarm_i, servo_on_i};
         sync2_r <= sync1_r;
      end
   end

   assign servo_on = sync2_r[0] && !fault;
   assign fault = sync2_r[1] || sync2_r[2];

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [15:0] on_delay_r;
   logic [15:0] off_delay_r;
   logic [15:0] speed_thr_r;
   logic [7:0] do_func_r;
   brake_pkg::brake_state_t state_r;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         on_delay_r <= brake_pkg::DELAY_RESET;
         off_delay_r <= brake_pkg::DELAY_RESET;
         speed_thr_r <= brake_pkg::THR_RESET;
         do_func_r <= brake_pkg::FUNC_RESET;
      end else if (wr_i) begin
         unique case (addr_i)
            brake_pkg::ADDR_ON_DELAY: on_delay_r <= wdata_i;
            brake_pkg::ADDR_OFF_DELAY: off_delay_r <= wdata_i;
            brake_pkg::ADDR_SPEED_THR: speed_thr_r <= wdata_i;
            brake_pkg::ADDR_DO_FUNC: do_func_r <= wdata_i[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         unique case (addr_i)
            brake_pkg::ADDR_ON_DELAY: rdata_o <= on_delay_r;
            brake_pkg::ADDR_OFF_DELAY: rdata_o <= off_delay_r;
            brake_pkg::ADDR_SPEED_THR: rdata_o <= speed_thr_r;
            brake_pkg::ADDR_DO_FUNC: rdata_o <= {8'h00, do_func_r};
            brake_pkg::ADDR_STATUS: rdata_o <= {13'h0000, fault,
               state_r != brake_pkg::ST_LOCKED, brake_release_o};
            default: rdata_o <= 16'h0000;
         endcase
      end else begin
         rdata_o <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // delay clamping and speed compare
   // ----------------------------------------------------------------
   // out-of-range settings are clamped rather than refused
   function automatic logic [10:0] clamp_ms(input logic signed [15:0] v,
                                             input logic neg_to_zero);
      logic signed [15:0] m;
      m = v;
      if (m > 16'(brake_pkg::OFF_MAX_MS)) begin
         m = 16'(brake_pkg::OFF_MAX_MS);
      end
      if (m < 16'sh0000) begin
         m = 16'sh0000;
      end
      clamp_ms = neg_to_zero ? m[10:0] : m[10:0];
   endfunction

   logic [10:0] on_ms;
   logic [10:0] off_ms;
   logic off_negative;
   logic [15:0] speed_mag;
   logic slow;

   assign on_ms = clamp_ms(on_delay_r, 1'b1);
   assign off_ms = clamp_ms(off_delay_r, 1'b1);
   assign off_negative = off_delay_r[15];
   assign speed_mag = speed_i[15] ? 16'(-speed_i) : speed_i;
   assign slow = speed_mag < speed_thr_r;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   logic tick;
   logic restart;
   logic [10:0] cnt_r;
   logic servo_on_d_r;
   logic off_edge;
   logic on_edge;

   assign on_edge = servo_on && !servo_on_d_r;
   assign off_edge = !servo_on && servo_on_d_r;
   assign restart = on_edge || off_edge;

   ms_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .clear_i(restart),
      .tick_o(tick)
   );

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         servo_on_d_r <= 1'b0;
      end else begin
         servo_on_d_r <= servo_on;
      end
   end

   // negative turn-off delay is treated as zero: the brake locks the cycle after
   // servo-off is seen; a fault counts as servo-off and takes the same turn-off path
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_r <= brake_pkg::ST_LOCKED;
         cnt_r <= 11'h000;
      end else begin
         unique case (state_r)
            brake_pkg::ST_LOCKED: begin
               if (on_edge) begin
                  state_r <= (on_ms == 11'h000) ? brake_pkg::ST_RELEASED
                                                : brake_pkg::ST_ON_WAIT;
                  cnt_r <= on_ms;
               end
            end
            brake_pkg::ST_ON_WAIT: begin
               if (!servo_on) begin
                  state_r <= brake_pkg::ST_LOCKED;
               end else if (tick) begin
                  cnt_r <= cnt_r - 11'h001;
                  if (cnt_r == 11'h001) begin
                     state_r <= brake_pkg::ST_RELEASED;
                  end
               end
            end
            brake_pkg::ST_RELEASED: begin
               if (off_edge) begin
                  if (off_negative || off_ms == 11'h000 || slow) begin
                     state_r <= brake_pkg::ST_LOCKED;
                  end else begin
                     state_r <= brake_pkg::ST_OFF_WAIT;
                     cnt_r <= off_ms;
                  end
               end
            end
            brake_pkg::ST_OFF_WAIT: begin
               if (slow) begin
                  state_r <= brake_pkg::ST_LOCKED;
               end else if (tick) begin
                  cnt_r <= cnt_r - 11'h001;
                  if (cnt_r == 11'h001) begin
                     state_r <= brake_pkg::ST_LOCKED;
                  end
               end
            end
         endcase
      end
   end

   // high releases the brake, low locks it
   assign brake_release_o = (state_r == brake_pkg::ST_RELEASED) ||
                            (state_r == brake_pkg::ST_OFF_WAIT);
   assign brake_interlock_o = brake_release_o &&
                              (do_func_r == brake_pkg::FUNC_BRAKE);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence on_zero_s;
      on_edge && on_ms == 11'h000 && state_r == brake_pkg::ST_LOCKED;
   endsequence

   no_early_release_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      on_edge && on_ms != 11'h000 && state_r == brake_pkg::ST_LOCKED |=> !brake_release_o)
      else $error("brake released before turn-on delay");
   zero_on_delay_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      on_zero_s |=> brake_release_o)
      else $error("zero turn-on delay did not release");
   off_wait_entry_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      state_r == brake_pkg::ST_RELEASED && off_edge && !off_negative && !slow
      && off_ms != 11'h000 |=> state_r == brake_pkg::ST_OFF_WAIT && cnt_r == $past(off_ms))
      else $error("turn-off delay not loaded");
   slow_lock_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      state_r == brake_pkg::ST_OFF_WAIT && slow |=> !brake_release_o)
      else $error("slow motor did not lock brake");
   expiry_lock_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      state_r == brake_pkg::ST_OFF_WAIT && tick && cnt_r == 11'h001 |=> !brake_release_o)
      else $error("expired turn-off delay did not lock");
   fault_neg_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      state_r == brake_pkg::ST_RELEASED && off_edge && off_negative |=> !brake_release_o)
      else $error("negative delay not treated as zero");
   locked_low_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !servo_on |=> !brake_release_o || state_r == brake_pkg::ST_OFF_WAIT)
      else $error("brake released without servo on");
   func_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      do_func_r != brake_pkg::FUNC_BRAKE |-> !brake_interlock_o)
      else $error("interlock on with other function code");
   reg_reset_a: assert property (@(posedge core_clk_i)
      $rose(rst_n_i) |-> on_delay_r == 16'h0000 && off_delay_r == 16'h0000)
      else $error("delay registers not reset to zero");
   tick_count_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      state_r == brake_pkg::ST_ON_WAIT && servo_on && !tick |=> $stable(cnt_r))
      else $error("delay counted without tick");
endmodule // brake_interlock_sequencer

// ==== bench/motor_model.sv ====
// motor and brake stand-in driving the measured speed
`timescale 1ns/100ps
module motor_model (
   input wire logic core_clk_i,
   input wire logic brake_release_i,
   input wire logic signed [15:0] target_i,
   output logic signed [15:0] speed_o
);
   // an engaged brake holds the shaft; speed is registered, so it reads zero from the cycle after the brake engages
   always_ff @(posedge core_clk_i) begin
      speed_o <= brake_release_i ? target_i : 16'sh0000;
   end
endmodule // motor_model

// ==== bench/brake_interlock_sequencer_bench.sv ====
// self-checking bench for the brake interlock sequencer
`timescale 1ns/100ps
module brake_interlock_sequencer_bench;
   localparam int TK = 4;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [11:0] addr_i = 12'h0000;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic servo_on_i = 1'b0;
   logic alarm_i = 1'b0;
   logic emergency_stop_in_i = 1'b0;
   logic signed [15:0] target = 16'sh0000;
   logic signed [15:0] speed_i;
   logic [15:0] rdata_o;
   logic brake_release_o;
   logic brake_interlock_o;
   int mismatches = 0;
   int checks_done = 0;
   typedef struct {logic [11:0] a; logic [15:0] d; logic [15:0] e;} row_t;
   row_t rows [6] = '{
      '{brake_pkg::ADDR_ON_DELAY, 16'h03e8, 16'h03e8},
      '{brake_pkg::ADDR_OFF_DELAY, 16'h03e8, 16'h03e8},
      '{brake_pkg::ADDR_SPEED_THR, 16'h0010, 16'h0010},
      '{12'h0100, 16'habcd, 16'h0000},
      '{brake_pkg::ADDR_ON_DELAY, 16'h0003, 16'h0003},
      '{brake_pkg::ADDR_OFF_DELAY, 16'h0005, 16'h0005}};

   brake_interlock_sequencer #(.TICK_CYCLES(TK)) brake_interlock_sequencer_inst (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .servo_on_i(servo_on_i),
      .alarm_i(alarm_i), .emergency_stop_in_i(emergency_stop_in_i), .speed_i(speed_i),
      .brake_release_o(brake_release_o), .brake_interlock_o(brake_interlock_o));
   motor_model motor_model_inst (.core_clk_i(core_clk_i), .brake_release_i(brake_release_o),
      .target_i(target), .speed_o(speed_i));

   initial begin
      forever #2 core_clk_i = ~core_clk_i;
   end

   // ------------------------------
   // shared tasks
   // ------------------------------
   task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // every bus request starts right after a rising edge
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 check("rdata", e, rdata_o);
   endtask
   task automatic servo(input logic v);
      @(posedge core_clk_i);
      servo_on_i <= v;
   endtask
   // bounded wait for the release output to reach a level
   task automatic reach(input logic v, input int n);
      int k;
      k = 0;
      while (brake_release_o !== v && k < n) begin
         @(posedge core_clk_i);
         #1 k++;
      end
      check("release", {15'h0000, v}, {15'h0000, brake_release_o});
   endtask
   // early change of the release output counts as a fault
   task automatic stay(input logic v, input int n);
      logic [15:0] bad;
      bad = 16'h0000;
      repeat (n) begin
         @(posedge core_clk_i);
         #1 if (brake_release_o !== v) bad++;
      end
      check("release_hold", 16'h0000, bad);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #100000;
      mismatches++;
      give_verdict();
   end

   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      repeat (16) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      rd(brake_pkg::ADDR_ON_DELAY, 16'h0000);
      rd(brake_pkg::ADDR_OFF_DELAY, 16'h0000);
      rd(brake_pkg::ADDR_DO_FUNC, 16'h0007);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      // negative speed: only the magnitude may be compared
      servo(1'b1);
      target <= -16'sh0100;
      // two sync flops, edge, restart, then three ticks of TK cycles
      stay(1'b0, 3 * TK + 3);
      reach(1'b1, 2);
      check("interlock", 16'h0001, {15'h0000, brake_interlock_o});
      rd(brake_pkg::ADDR_STATUS, 16'h0003);
      servo(1'b0);
      stay(1'b1, 5 * TK + 3);
      reach(1'b0, 2);
      servo(1'b1);
      reach(1'b1, 24);
      // speed falls while the turn-off delay is still running
      servo(1'b0);
      repeat (6) @(posedge core_clk_i);
      target <= 16'sh0000;
      reach(1'b0, 4);
      wr(brake_pkg::ADDR_OFF_DELAY, 16'hfffb);
      target <= -16'sh0100;
      for (int f = 0; f < 2; f++) begin
         servo(1'b1);
         reach(1'b1, 24);
         @(posedge core_clk_i);
         alarm_i <= (f == 0);
         emergency_stop_in_i <= (f == 1);
         servo_on_i <= 1'b0;
         reach(1'b0, 8);
         rd(brake_pkg::ADDR_STATUS, 16'h0004);
         @(posedge core_clk_i);
         alarm_i <= 1'b0;
         emergency_stop_in_i <= 1'b0;
         repeat (4) @(posedge core_clk_i);
      end
      wr(brake_pkg::ADDR_DO_FUNC, 16'h0000);
      servo(1'b1);
      reach(1'b1, 24);
      check("interlock", 16'h0000, {15'h0000, brake_interlock_o});
      servo(1'b0);
      reach(1'b0, 8);
      // zero turn-on delay releases as soon as servo-on is seen
      wr(brake_pkg::ADDR_ON_DELAY, 16'h0000);
      servo(1'b1);
      reach(1'b1, 4);
      // reset in mid-run drops the release and returns the settings to their reset values
      @(posedge core_clk_i);
      rst_n_i <= 1'b0;
      servo_on_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      #1 check("release_rst", 16'h0000, {15'h0000, brake_release_o});
      rd(brake_pkg::ADDR_ON_DELAY, 16'h0000);
      rd(brake_pkg::ADDR_OFF_DELAY, 16'h0000);
      rd(brake_pkg::ADDR_DO_FUNC, 16'h0007);
      give_verdict();
   end
endmodule // brake_interlock_sequencer_bench
